// [hw/lfd_consts.vh]
`ifndef LFD_CONSTS_VH
`define LFD_CONSTS_VH
// i2c slave address, 7-bit
`define LFD_I2C_ADDR      7'h28
// mode control register fields
`define LFD_MODE_HI       7
`define LFD_MODE_LO       6
`define LFD_SAVE_BIT      5
`define LFD_GAIN_HI       4
`define LFD_GAIN_LO       3
`define LFD_TMO_HI        1
`define LFD_TMO_LO        0
// operation patterns of the top two mode bits
`define LFD_OP_TORCH_HE   2'b01
`define LFD_OP_TORCH_AG   2'b10
`define LFD_OP_FLASH      2'b11
// voltage/fault register fields
`define LFD_VLIM_HI       7
`define LFD_VLIM_LO       5
`define LFD_RDY_BIT       4
`define LFD_UNDERVOLTAGE_LOCKOUT_FLAG_BIT      3
`define LFD_TEMP_BIT      2
// current registers fields
`define LFD_EN_HI         7
`define LFD_EN_LO         5
`define LFD_FDAC_HI       4
`define LFD_FDAC_LO       2
`define LFD_TDAC_HI       4
`define LFD_TDAC_LO       1
// reset value of every register
`define LFD_REG_RST       8'h00
// synchroniser reset: scl, sda and shutdown pins idle high
`define LFD_PIN_IDLE      7'h07
// flash durations in ms and cycles at 125 mhz
`define LFD_CLK_MHZ       125
`define LFD_T0_MS         110
`define LFD_T1_MS         220
`define LFD_T2_MS         530
`define LFD_T3_MS         1100
`define LFD_MS_CYC(ms)    ((ms) * 1000 * `LFD_CLK_MHZ)
`endif

// [hw/lfd_regs.v]
`include "lfd_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module lfd_regs #(
  parameter [31:0] T0_CYC = `LFD_MS_CYC(`LFD_T0_MS),  // 0.11 s
  parameter [31:0] T1_CYC = `LFD_MS_CYC(`LFD_T1_MS),  // 0.22 s
  parameter [31:0] T2_CYC = `LFD_MS_CYC(`LFD_T2_MS),  // 0.53 s
  parameter [31:0] T3_CYC = `LFD_MS_CYC(`LFD_T3_MS)   // 1.10 s
) (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       shutdown_n,       // active-low shutdown pin
  input  wire       scl_in,           // i2c clock pin
  input  wire       sda_in,           // i2c data pin level
  output reg        sda_oe_n_ff,      // low while pulling sda low
  output reg        sda_out_ff,       // always low when driven
  input  wire       flash_trig,       // flash trigger pin
  input  wire       vout_over_limit,  // analog comparator status
  input  wire       undervoltage_lockout_flag_det,         // undervoltage detector
  input  wire       otemp_det,        // over-temperature detector
  output reg  [7:0] mode_control_register_ff,
  output reg  [7:0] flash_current_register_ff,
  output reg  [7:0] torch_current_register_ff,
  output reg  [2:0] vout_limit_code_ff,
  output reg        shutdown_ff,      // high in shutdown mode
  output reg        torch_on_ff,      // torch mode active
  output reg        flash_on_ff,      // leds lit for flash
  output reg  [1:0] gain_sel_ff,      // 0 auto/he, 1 1x, 2 1.5x, 3 2x
  output reg  [2:0] led_en_ff,        // channel 1..3 enables
  output reg  [3:0] led_dac_ff        // active current code
);
  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every asynchronous pin
  reg [6:0] sync1_ff;
  reg [6:0] sync2_ff;
  wire [6:0] pins = {otemp_det, undervoltage_lockout_flag_det, vout_over_limit, flash_trig, shutdown_n, sda_in, scl_in};
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // scl, sda and shutdown pins idle high; starting the chain at
      // those levels keeps a false scl edge, a phantom stop and a
      // spurious shutdown out of the first cycles after reset
      sync1_ff <= `LFD_PIN_IDLE;
      sync2_ff <= `LFD_PIN_IDLE;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end
  wire scl_s  = sync2_ff[0];
  wire sda_s  = sync2_ff[1];
  wire sdn_s  = sync2_ff[2];
  wire trig_s = sync2_ff[3];
  wire vov_s  = sync2_ff[4];
  wire uv_s   = sync2_ff[5];
  wire ot_s   = sync2_ff[6];
  ////////////////////////////////////////////////////////////////////////
  // edge and bus-condition detection on synchronised lines
  // start and stop need scl high on two samples in a row, which keeps
  // an sda edge close to an scl edge from faking either condition
  reg scl_d_ff;
  reg sda_d_ff;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire i2c_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire i2c_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  ////////////////////////////////////////////////////////////////////////
  // i2c byte engine, one-hot states
  // limitation: no clock stretching; the engine relies on the master's
  // scl low time being several clocks long to settle sda
  localparam [4:0] ST_IDLE = 5'b00001;  // waiting for start
  localparam [4:0] ST_ADDR = 5'b00010;  // shifting address byte
  localparam [4:0] ST_WR   = 5'b00100;  // receiving data
  localparam [4:0] ST_RD   = 5'b01000;  // sending data
  localparam [4:0] ST_ACK  = 5'b10000;  // ack slot (either way)
  reg  [4:0] state_ff;
  reg  [4:0] nxt_state;
  reg  [3:0] bitcnt_ff;         // bits seen in current byte
  reg  [7:0] shift_ff;          // shift register
  reg  [1:0] ptr_ff;            // register pointer
  reg        is_read_ff;        // transfer direction
  reg        addr_phase_ff;     // ack slot belongs to address
  reg        master_nack_ff;    // master ended read
  reg        txn_seen_ff;       // a command has been addressed
  // read-back byte for the pointer
  // pointer 3 wraps to the mode register, so a long read still
  // returns every byte of the bank once
  function [7:0] rd_byte;
    input [1:0] p;
    input [7:0] m, v, f, t;
    begin
      case (p)
        2'd0:    rd_byte = v;  // status first on read
        2'd1:    rd_byte = f;
        2'd2:    rd_byte = t;
        default: rd_byte = m;
      endcase
    end
  endfunction
  reg [7:0] vf_reg_ff;          // voltage/fault register image
  // status bits come live from the synchronised pins, so a read
  // shows the level at the moment the byte is loaded
  wire [7:0] vf_read = {vf_reg_ff[7:5], vov_s, uv_s, ot_s, 2'b00};
  // address sits in the upper seven bits, direction in bit 0
  wire addr_match = (shift_ff[7:1] == `LFD_I2C_ADDR);
  // next read byte, decoded once for the shifter and the pin
  wire [7:0] rd_next = rd_byte(ptr_ff, mode_control_register_ff, vf_read,
                               flash_current_register_ff, torch_current_register_ff);
  // register write strobes
  reg        wr_stb_ff;
  reg  [1:0] wr_idx_ff;
  reg  [7:0] wr_dat_ff;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 2'd0;
      is_read_ff <= 1'b0;
      addr_phase_ff <= 1'b0;
      master_nack_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      sda_out_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_idx_ff <= 2'd0;
      wr_dat_ff <= 8'h00;
      txn_seen_ff <= 1'b0;
    end else begin
      // write and command strobes are one-cycle pulses
      wr_stb_ff <= 1'b0;
      txn_seen_ff <= 1'b0;
      // a start wins over everything, so a repeated start
      // abandons any byte in flight and rewinds the pointer
      if (i2c_start) begin
        // pointer restarts at every transfer
        state_ff <= ST_ADDR;
        bitcnt_ff <= 4'h0;
        ptr_ff <= 2'd0;
        sda_oe_n_ff <= 1'b1;
      // stop or shutdown drops the bus; the line is let go so the
      // master never finds sda held low by a dead transfer
      end else if (i2c_stop || !sdn_s) begin
        state_ff <= ST_IDLE;
        sda_oe_n_ff <= 1'b1;
      end else begin
        state_ff <= nxt_state;
        case (state_ff)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (scl_fall && bitcnt_ff == 4'd8) begin
              bitcnt_ff <= 4'h0;
              addr_phase_ff <= state_ff[1];
              if (state_ff[1]) begin
                is_read_ff <= shift_ff[0];
                if (addr_match) begin
                  sda_oe_n_ff <= 1'b0;
                  txn_seen_ff <= 1'b1;
                end
              end else begin
                // ack and store data byte, bump pointer
                sda_oe_n_ff <= 1'b0;
                wr_stb_ff <= 1'b1;
                wr_idx_ff <= ptr_ff;
                wr_dat_ff <= shift_ff;
                ptr_ff <= ptr_ff + 2'd1;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise && !addr_phase_ff && is_read_ff)
              master_nack_ff <= sda_s;
            if (scl_fall) begin
              bitcnt_ff <= 4'h0;
              if (is_read_ff && (addr_phase_ff || !master_nack_ff)) begin
                // present msb of next read byte
                shift_ff <= rd_next;
                // msb goes out at once; a one simply lets the line go
                sda_oe_n_ff <= rd_next[7];
                ptr_ff <= ptr_ff + 2'd1;
              end else begin
                sda_oe_n_ff <= 1'b1;
              end
            end
          end
          ST_RD: begin
            if (scl_rise)
              bitcnt_ff <= bitcnt_ff + 4'h1;
            if (scl_fall) begin
              if (bitcnt_ff == 4'd8) begin
                sda_oe_n_ff <= 1'b1;  // release for master ack
                bitcnt_ff <= 4'h0;
                addr_phase_ff <= 1'b0;
              end else begin
                shift_ff <= {shift_ff[6:0], 1'b0};
                sda_oe_n_ff <= shift_ff[6];
              end
            end
          end
          default: ;
        endcase
      end
    end
  end
  // next-state decode; every move happens on a synced scl fall,
  // so sda is only ever changed while scl is low
  // a missed address parks the engine in idle until the next start
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_ADDR: if (scl_fall && bitcnt_ff == 4'd8)
                 nxt_state = addr_match ? ST_ACK : ST_IDLE;
      ST_WR:   if (scl_fall && bitcnt_ff == 4'd8) nxt_state = ST_ACK;
      ST_RD:   if (scl_fall && bitcnt_ff == 4'd8) nxt_state = ST_ACK;
      ST_ACK:  if (scl_fall)
                 nxt_state = !is_read_ff ? ST_WR :
                             (addr_phase_ff || !master_nack_ff) ? ST_RD : ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // register bank; save bit decides persistence between commands
  // priority: shutdown, then the save-bit clear, then writes; the clear
  // comes at the address ack, long before the first data byte, so a
  // command that drops old state still stores its own new bytes
  wire save = mode_control_register_ff[`LFD_SAVE_BIT];
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_control_register_ff <= `LFD_REG_RST;
      vf_reg_ff <= `LFD_REG_RST;
      flash_current_register_ff <= `LFD_REG_RST;
      torch_current_register_ff <= `LFD_REG_RST;
    end else if (!sdn_s) begin
      mode_control_register_ff <= `LFD_REG_RST;
      vf_reg_ff <= `LFD_REG_RST;
      flash_current_register_ff <= `LFD_REG_RST;
      torch_current_register_ff <= `LFD_REG_RST;
    end else if (txn_seen_ff && !save) begin
      // contents dropped ahead of the new command
      mode_control_register_ff <= `LFD_REG_RST;
      vf_reg_ff <= `LFD_REG_RST;
      flash_current_register_ff <= `LFD_REG_RST;
      torch_current_register_ff <= `LFD_REG_RST;
    end else if (wr_stb_ff) begin
      // kept when save set
      case (wr_idx_ff)
        2'd0: mode_control_register_ff <= wr_dat_ff;
        2'd1: flash_current_register_ff <= wr_dat_ff;
        2'd2: torch_current_register_ff <= wr_dat_ff;
        default: vf_reg_ff <= {wr_dat_ff[7:5], 5'b00000};
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // flash timer: one duration per trigger, retrigger after expiry
  // the trigger is edge-sensitive: a level held past expiry does not
  // relight the leds, the pin has to fall and rise again
  // leaving flash mode or shutting down aborts a running flash at once
  // a rising edge while lit is ignored, so a flash is never stretched
  wire [1:0] op = mode_control_register_ff[`LFD_MODE_HI:`LFD_MODE_LO];
  wire [1:0] tsel = mode_control_register_ff[`LFD_TMO_HI:`LFD_TMO_LO];
  wire [31:0] dur = (tsel == 2'd0) ? T0_CYC : (tsel == 2'd1) ? T1_CYC :
                    (tsel == 2'd2) ? T2_CYC : T3_CYC;
  reg [31:0] tmr_ff;
  reg        trig_d_ff;
  wire flash_mode = sdn_s && (op == `LFD_OP_FLASH);
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_ff <= 32'h0000_0000;
      trig_d_ff <= 1'b0;
    end else begin
      trig_d_ff <= trig_s;
      if (!flash_mode)
        tmr_ff <= 32'h0000_0000;
      else if (tmr_ff != 32'h0000_0000)
        tmr_ff <= tmr_ff - 32'h0000_0001;
      else if (trig_s && !trig_d_ff)
        tmr_ff <= dur;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registered analog control outputs
  // every control is a flop so the analog side never sees a glitch
  // while the bank updates; the cost is one cycle of lag
  // the led mux follows the mode, not the lit state, to keep it steady
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      vout_limit_code_ff <= 3'b000;
      shutdown_ff <= 1'b1;
      torch_on_ff <= 1'b0;
      flash_on_ff <= 1'b0;
      gain_sel_ff <= 2'b00;
      led_en_ff <= 3'b000;
      led_dac_ff <= 4'h0;
    end else begin
      vout_limit_code_ff <= vf_reg_ff[`LFD_VLIM_HI:`LFD_VLIM_LO];
      shutdown_ff <= !sdn_s || op == 2'b00;
      torch_on_ff <= sdn_s && (op == `LFD_OP_TORCH_HE || op == `LFD_OP_TORCH_AG);
      flash_on_ff <= flash_mode && (tmr_ff != 32'h0000_0000);
      gain_sel_ff <= mode_control_register_ff[`LFD_GAIN_HI:`LFD_GAIN_LO];
      if (flash_mode) begin
        led_en_ff <= flash_current_register_ff[`LFD_EN_HI:`LFD_EN_LO];
        led_dac_ff <= {1'b0, flash_current_register_ff[`LFD_FDAC_HI:`LFD_FDAC_LO]};
      end else begin
        led_en_ff <= torch_current_register_ff[`LFD_EN_HI:`LFD_EN_LO];
        led_dac_ff <= torch_current_register_ff[`LFD_TDAC_HI:`LFD_TDAC_LO];
      end
    end
  end
endmodule // lfd_regs
`default_nettype wire

// [tb/lfd_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// watches the register bank pins only
module lfd_regs_chk #(
  parameter [31:0] T0_CYC = 32'h0000_0032,
  parameter [31:0] T1_CYC = 32'h0000_0064,
  parameter [31:0] T2_CYC = 32'h0000_00c8,
  parameter [31:0] T3_CYC = 32'h0000_0190
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       shutdown_n,
  input wire logic       scl_in,
  input wire logic       sda_oe_n_ff,
  input wire logic       sda_out_ff,
  input wire logic [7:0] mode_control_register_ff,
  input wire logic [7:0] flash_current_register_ff,
  input wire logic [7:0] torch_current_register_ff,
  input wire logic       shutdown_ff,
  input wire logic       torch_on_ff,
  input wire logic       flash_on_ff,
  input wire logic [1:0] gain_sel_ff,
  input wire logic [2:0] led_en_ff,
  input wire logic [3:0] led_dac_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] fcnt_ff;  // cycles lit so far
  wire  [31:0] tsel;     // duration picked by the mode bits
  assign tsel = mode_control_register_ff[1] ? (mode_control_register_ff[0] ? T3_CYC : T2_CYC)
                                            : (mode_control_register_ff[0] ? T1_CYC : T0_CYC);
  // count lit cycles, cleared while dark
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      fcnt_ff <= 32'h0000_0000;
    else
      fcnt_ff <= flash_on_ff ? fcnt_ff + 32'h0000_0001 : 32'h0000_0000;
  end
  ///////////////////////////////////////////////////////////////////////////
  shutdown_clr_a: assert property (!shutdown_n [*5]
    |-> shutdown_ff && !flash_on_ff && mode_control_register_ff == 8'h00)
    else $error("shutdown pin did not clear state");
  flash_len_a: assert property ($fell(flash_on_ff) && shutdown_n |-> fcnt_ff == tsel)
    else $error("flash length wrong");
  flash_src_a: assert property ($rose(flash_on_ff) |-> mode_control_register_ff[7:6] == 2'b11)
    else $error("flash outside flash mode");
  flash_leds_a: assert property (flash_on_ff && $past(flash_on_ff)
    |-> led_en_ff == flash_current_register_ff[7:5] && led_dac_ff == {1'b0, flash_current_register_ff[4:2]})
    else $error("flash channels or code wrong");
  torch_leds_a: assert property (torch_on_ff && !flash_on_ff && $stable(torch_current_register_ff)
    && $stable(torch_on_ff)
    |-> led_en_ff == torch_current_register_ff[7:5] && led_dac_ff == torch_current_register_ff[4:1])
    else $error("torch channels or code wrong");
  torch_gain_a: assert property (torch_on_ff && $stable(mode_control_register_ff)
    |-> gain_sel_ff == mode_control_register_ff[4:3])
    else $error("torch gain wrong");
  sda_edge_a: assert property ($changed(sda_oe_n_ff) |-> !scl_in)
    else $error("sda moved while scl high");
  drive_low_a: assert property (!sda_oe_n_ff |-> sda_out_ff == 1'b0)
    else $error("sda driven high");
endmodule // lfd_regs_chk
`default_nettype wire

// [tb/lfd_i2c_mst.sv]
`timescale 1ns/10ps
`default_nettype none
// far-side i2c master; scl stands high between frames, sda has a pull-up
module lfd_i2c_mst (
  output logic      scl_o,   // link clock
  output logic      sda_lo,  // high pulls sda low
  input  wire logic sda      // resolved sda level
);
  localparam real Q = 31.25;  // quarter of the 125 ns link period
  initial begin
    scl_o = 1'b1;
    sda_lo = 1'b0;
  end
  // start: sda falls while scl high
  task start;
    sda_lo = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_lo = 1'b1;
    #Q scl_o = 1'b0;
  endtask
  // one bit: set while scl low, sampled mid-high
  task bit_io(input logic b, output logic r);
    sda_lo = !b;
    #Q scl_o = 1'b1;
    #Q r = sda;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  // byte msb first, ninth bit a (1 releases the line)
  task xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask
  // stop: sda rises while scl high
  task stop;
    sda_lo = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_lo = 1'b0;
    #(2*Q);
  endtask
endmodule // lfd_i2c_mst
`default_nettype wire

// [tb/tb_top.sv]
`include "lfd_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic [31:0] tcyc [4] = '{32'h0000_0032, 32'h0000_0064, 32'h0000_00c8, 32'h0000_0190};
  logic        clock, sys_rst, shutdown_n, flash_trig;  // core inputs
  logic        ovl, uv, ot;                             // analog status pins
  logic        sda_lo;                                  // master pulls sda
  wire         scl, sda_oe_n, sda_out, shdn, torch_on, flash_on;
  wire  [7:0]  mode_r, fl_r, to_r;
  wire  [2:0]  vlim, led_en;
  wire  [1:0]  gain;
  wire  [3:0]  dac;
  wire         sda = !(sda_lo || (!sda_oe_n && !sda_out));  // pull-up when released
  int          n_fail, comparisons, seed, n;
  logic [31:0] w, q;
  always #4 clock = !clock;
  lfd_i2c_mst mst_u (.scl_o(scl), .sda_lo(sda_lo), .sda(sda));
  lfd_regs #(.T0_CYC(32'h0000_0032), .T1_CYC(32'h0000_0064), .T2_CYC(32'h0000_00c8), .T3_CYC(32'h0000_0190)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .shutdown_n(shutdown_n), .scl_in(scl), .sda_in(sda),
    .sda_oe_n_ff(sda_oe_n), .sda_out_ff(sda_out), .flash_trig(flash_trig), .vout_over_limit(ovl),
    .undervoltage_lockout_flag_det(uv), .otemp_det(ot), .mode_control_register_ff(mode_r), .flash_current_register_ff(fl_r),
    .torch_current_register_ff(to_r), .vout_limit_code_ff(vlim), .shutdown_ff(shdn), .torch_on_ff(torch_on),
    .flash_on_ff(flash_on), .gain_sel_ff(gain), .led_en_ff(led_en), .led_dac_ff(dac));
  ///////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // status byte: limit code plus live pin levels, low bits zero
  function logic [7:0] st(input logic [2:0] v);
    st = {v, ovl, uv, ot, 2'b00};
  endfunction
  task cyc(input int c);
    repeat (c) @(negedge clock);
  endtask
  task wr(input logic [6:0] a, input logic [31:0] d, input int nb);
    logic [7:0] r;
    logic k;
    mst_u.start();
    mst_u.xfer({a, 1'b0}, 1'b1, r, k);
    chk(!k, a == `LFD_I2C_ADDR);
    for (int i = 0; i < nb && !k; i++) begin
      mst_u.xfer(d[31-8*i -: 8], 1'b1, r, k);
      chk(!k, 1);
    end
    mst_u.stop();
  endtask
  task rd(output logic [31:0] d);
    logic [7:0] r;
    logic k;
    mst_u.start();
    mst_u.xfer({`LFD_I2C_ADDR, 1'b1}, 1'b1, r, k);
    chk(!k, 1);
    for (int i = 0; i < 4; i++) begin
      mst_u.xfer(8'hff, i == 3, r, k);
      d[31-8*i -: 8] = r;
    end
    mst_u.stop();
  endtask
  // trigger, count lit cycles; a retrigger mid-flash must not stretch it
  task flash(output int c);
    c = 0;
    flash_trig = 1'b1;
    for (int i = 0; i < 10 && !flash_on; i++) cyc(1);
    while (flash_on === 1'b1 && c < 1000) begin
      flash_trig = c < 5 || (c >= 20 && c < 25);
      cyc(1);
      c++;
    end
    flash_trig = 1'b0;
  endtask
  task summarize;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ///////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2457;
    {clock, sys_rst, shutdown_n, flash_trig} = 4'h6;
    {ovl, uv, ot} = 3'b000;
    cyc(8);
    sys_rst = 1'b0;
    cyc(4);
    {ovl, uv, ot} = 3'($random(seed));
    cyc(4);
    rd(q);
    chk(q, {st(3'h0), 24'h00_0000});
    $display("reset test done");
    // every operation and gain pattern, saved across commands
    for (int op = 1; op < 4; op++) begin
      for (int g = 0; g < 4; g++) begin
        w = $random(seed);
        w[31:27] = {op[1:0], 1'b1, g[1:0]};
        wr(`LFD_I2C_ADDR, w, 4);
        cyc(4);
        chk({mode_r, fl_r, to_r, 5'h00, vlim}, {w[31:8], 5'h00, w[7:5]});
        chk({shdn, torch_on, gain}, {1'b0, op != 3, g[1:0]});
        if (op != 3) chk({led_en, dac}, {w[15:13], w[12:9]});
        else chk({led_en, dac}, {w[23:21], 1'b0, w[20:18]});
        {ovl, uv, ot} = 3'($random(seed));
        cyc(4);
        rd(q);
        chk(q, {st(w[7:5]), w[23:8], w[31:24]});
      end
    end
    $display("mode test done");
    wr(7'h29, $random(seed), 4);
    chk(mode_r, q[7:0]);
    w = $random(seed);
    w[29] = 1'b0;
    wr(`LFD_I2C_ADDR, w, 4);
    rd(q);
    chk(q, {st(3'h0), 24'h00_0000});
    chk(mode_r, 8'h00);
    $display("address and save test done");
    for (int k = 0; k < 4; k++) begin
      w = $random(seed);
      w[31:29] = 3'b111;
      w[25:24] = k[1:0];
      wr(`LFD_I2C_ADDR, w, 3);
      cyc(4);
      flash(n);
      chk(n, tcyc[k]);
      cyc(4);
      flash(n);
      chk(n, tcyc[k]);
    end
    $display("flash test done");
    cyc(2);
    flash_trig = 1'b1;
    cyc(10);
    chk(flash_on, 1'b1);
    shutdown_n = 1'b0;
    cyc(6);
    chk({shdn, flash_on, mode_r, fl_r, to_r, vlim}, 29'h1000_0000);
    shutdown_n = 1'b1;
    flash_trig = 1'b0;
    cyc(6);
    $display("shutdown test done");
    summarize();
  end
  // the run needs about 25,000 cycles; three times that means a hang
  initial begin
    #600_000;
    n_fail++;
    summarize();
  end
endmodule // tb_top
bind lfd_regs lfd_regs_chk #(.T0_CYC(T0_CYC), .T1_CYC(T1_CYC), .T2_CYC(T2_CYC), .T3_CYC(T3_CYC)) chk_u (
  .clock, .sys_rst, .shutdown_n, .scl_in, .sda_oe_n_ff, .sda_out_ff, .mode_control_register_ff,
  .flash_current_register_ff, .torch_current_register_ff, .shutdown_ff, .torch_on_ff, .flash_on_ff,
  .gain_sel_ff, .led_en_ff, .led_dac_ff);
`default_nettype wire
